// ### hdl/eee_tx_gate.sv
// Per-port transmit power gating for energy efficient Ethernet egress, and its word FIFO.
// Assumes egress queues report each enqueue with byte count and queue id,
// and that the MAC side accepts words on tx_valid/tx_ready.
`timescale 1ns/1ps
module eee_tx_gate #(
  parameter int NUM_PORTS = 8,
  parameter int QUEUES    = 8
) (
  input  wire logic                                         pclk,
  input  wire logic                                         presetn,
  input  wire logic [eee_gate_pkg::APB_AW-1:0]              paddr,
  input  wire logic                                         psel,
  input  wire logic                                         penable,
  input  wire logic                                         pwrite,
  input  wire logic [eee_gate_pkg::DATA_W-1:0]              pwdata,
  input  wire logic [3:0]                                   pstrb,
  output logic      [eee_gate_pkg::DATA_W-1:0]              prdata,
  output logic                                              pready,
  output logic                                              pslverr,
  input  wire logic [NUM_PORTS-1:0]                         q_add_valid,
  input  wire logic [NUM_PORTS*eee_gate_pkg::ADD_W-1:0]     q_add_bytes,
  input  wire logic [NUM_PORTS*$clog2(QUEUES)-1:0]          q_add_queue,
  input  wire logic [NUM_PORTS-1:0]                         q_empty,
  input  wire logic [NUM_PORTS-1:0]                         link_gig,
  input  wire logic                                         in_valid,
  output logic                                              in_ready,
  input  wire logic [$clog2(NUM_PORTS)-1:0]                 in_port,
  input  wire logic [eee_gate_pkg::DATA_W-1:0]              in_data,
  output logic                                              tx_valid,
  input  wire logic                                         tx_ready,
  output logic      [$clog2(NUM_PORTS)-1:0]                 tx_port,
  output logic      [eee_gate_pkg::DATA_W-1:0]              tx_data,
  output logic      [NUM_PORTS-1:0]                         tx_power_up
);
  import eee_gate_pkg::*;

  localparam int PORT_W = $clog2(NUM_PORTS);
  localparam int QID_W  = $clog2(QUEUES);
  localparam int FW     = PORT_W + DATA_W;

  if (NUM_PORTS < 2 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
    $error("eee_tx_gate: NUM_PORTS out of range");
  end
  if (QUEUES < 2 || QUEUES > MAX_QUEUES) begin : g_bad_queues
    $error("eee_tx_gate: QUEUES out of range");
  end

  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] new_v,
                                              input logic [3:0]        strb);
    logic [DATA_W-1:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Configuration and status
  logic [NUM_PORTS-1:0] en_q;
  logic [CNT_W-1:0]     wake_gig_q;
  logic [CNT_W-1:0]     wake_oth_q;
  logic [QUEUES-1:0]    urg_q [NUM_PORTS];
  logic [NUM_PORTS-1:0] port_active;
  logic [NUM_PORTS-1:0] port_powered;

  // APB decode
  logic              wr_en;
  logic              rd_setup;
  logic              urg_hit;
  logic [PORT_W-1:0] urg_idx;
  logic              hit_d;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] prdata_q;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign urg_idx  = paddr[URG_IDX_LSB +: PORT_W];
  assign urg_hit  = (paddr[APB_AW-1:URG_REG_LSB] == URG_REGION)
                    && ({1'b0, paddr[URG_REG_LSB-1:URG_IDX_LSB]} < (URG_REG_LSB - URG_IDX_LSB + 1)'(NUM_PORTS));
  // Zero wait states: read data is captured in the setup cycle
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit_d;
  assign prdata   = prdata_q;

  always_comb begin
    hit_d   = 1'b1;
    rdata_d = '0;
    if (paddr == REG_ENABLE) begin
      rdata_d[NUM_PORTS-1:0] = en_q;
    end else if (paddr == REG_WAKE_GIG) begin
      rdata_d[CNT_W-1:0] = wake_gig_q;
    end else if (paddr == REG_WAKE_OTH) begin
      rdata_d[CNT_W-1:0] = wake_oth_q;
    end else if (paddr == REG_STATUS) begin
      rdata_d[NUM_PORTS-1:0]                = port_powered;
      rdata_d[STAT_ACT_LSB +: NUM_PORTS]    = port_active;
    end else if (urg_hit) begin
      rdata_d[QUEUES-1:0] = urg_q[urg_idx];
    end else begin
      hit_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (rd_setup) begin
      prdata_q <= rdata_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
    end else if (wr_en && paddr == REG_ENABLE) begin
      en_q <= NUM_PORTS'(merge(DATA_W'(en_q), pwdata, pstrb));
    end
  end

  // Software installs the value learned from the partner here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_gig_q <= WAKE_GIG_RST;
      wake_oth_q <= WAKE_OTH_RST;
    end else if (wr_en) begin
      if (paddr == REG_WAKE_GIG) begin
        wake_gig_q <= CNT_W'(merge(DATA_W'(wake_gig_q), pwdata, pstrb));
      end
      if (paddr == REG_WAKE_OTH) begin
        wake_oth_q <= CNT_W'(merge(DATA_W'(wake_oth_q), pwdata, pstrb));
      end
    end
  end

  // Data path
  logic              fifo_ovalid;
  logic              fifo_ordy;
  logic [FW-1:0]     fifo_odata;
  logic [PORT_W-1:0] head_port;
  logic              tx_valid_q;
  logic [PORT_W-1:0] tx_port_q;
  logic [DATA_W-1:0] tx_data_q;

  gate_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   ({in_port, in_data}),
    .out_valid (fifo_ovalid),
    .out_ready (fifo_ordy),
    .out_data  (fifo_odata)
  );

  assign head_port = fifo_odata[FW-1 -: PORT_W];
  // Head-of-line: a word for a sleeping port holds back words for awake ports
  assign fifo_ordy = fifo_ovalid && port_active[head_port] && (!tx_valid_q || tx_ready);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid_q <= 1'b0;
      tx_port_q  <= '0;
      tx_data_q  <= '0;
    end else if (fifo_ordy) begin
      tx_valid_q <= 1'b1;
      tx_port_q  <= head_port;
      tx_data_q  <= fifo_odata[DATA_W-1:0];
    end else if (tx_ready) begin
      tx_valid_q <= 1'b0;
    end
  end

  assign tx_valid = tx_valid_q;
  assign tx_port  = tx_port_q;
  assign tx_data  = tx_data_q;

  // Per-port power state
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    pw_state_t         st_q;
    pw_state_t         st_d;
    logic [ACC_W-1:0]  acc_q;
    logic [ACC_W-1:0]  acc_sum;
    logic [CNT_W-1:0]  tmr_q;
    logic [CNT_W-1:0]  wk_q;
    logic [CNT_W-1:0]  wk_target;
    logic [QID_W-1:0]  qid;
    logic              add;
    logic              urgent_add;
    logic              head_here;
    logic              tx_here;

    assign add        = q_add_valid[p];
    assign qid        = q_add_queue[p*QID_W +: QID_W];
    assign acc_sum    = acc_q + ACC_W'(q_add_bytes[p*ADD_W +: ADD_W]);
    assign urgent_add = add && urg_q[p][qid];
    assign head_here  = fifo_ovalid && (head_port == PORT_W'(p));
    assign tx_here    = tx_valid_q && (tx_port_q == PORT_W'(p));
    assign wk_target  = link_gig[p] ? wake_gig_q : wake_oth_q;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        urg_q[p] <= '0;
      end else if (wr_en && urg_hit && urg_idx == PORT_W'(p)) begin
        urg_q[p] <= QUEUES'(merge(DATA_W'(urg_q[p]), pwdata, pstrb));
      end
    end

    always_comb begin
      st_d = st_q;
      case (st_q)
        PW_SLEEP: begin
          if (!en_q[p]) begin
            st_d = PW_WAKE;
          end else if (urgent_add) begin
            st_d = PW_WAKE;
          end else if (add && acc_sum >= ACC_W'(BYTE_THRESH)) begin
            st_d = PW_WAKE;
          end else if (add || head_here) begin
            st_d = PW_DEFER;
          end
        end
        PW_DEFER: begin
          if (!en_q[p] || urgent_add) begin
            st_d = PW_WAKE;
          end else if (add && acc_sum >= ACC_W'(BYTE_THRESH)) begin
            st_d = PW_WAKE;
          end else if (tmr_q >= CNT_W'(DEFER_CYC - 1)) begin
            st_d = PW_WAKE;
          end
        end
        PW_WAKE: begin
          if ({1'b0, wk_q} + 1'b1 >= {1'b0, wk_target}) begin
            st_d = PW_ACTIVE;
          end
        end
        PW_ACTIVE: begin
          // A word stalled in the output register keeps its port powered
          if (en_q[p] && q_empty[p] && !head_here && !tx_here && !add) begin
            st_d = PW_SLEEP;
          end
        end
        default: begin
          st_d = PW_SLEEP;
        end
      endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        st_q <= PW_SLEEP;
      end else begin
        st_q <= st_d;
      end
    end

    // Deferral accounting
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_q <= '0;
        tmr_q <= '0;
      end else if (st_d != PW_DEFER) begin
        acc_q <= '0;
        tmr_q <= '0;
      end else if (st_q == PW_SLEEP) begin
        acc_q <= add ? acc_sum : '0;
        tmr_q <= '0;
      end else begin
        acc_q <= add ? acc_sum : acc_q;
        tmr_q <= tmr_q + 1'b1;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wk_q <= '0;
      end else if (st_q == PW_WAKE) begin
        wk_q <= wk_q + 1'b1;
      end else begin
        wk_q <= '0;
      end
    end

    assign port_active[p]  = (st_q == PW_ACTIVE);
    assign port_powered[p] = (st_q == PW_WAKE) || (st_q == PW_ACTIVE);
  end

  assign tx_power_up = port_powered;
endmodule

module gate_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("gate_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW:0]      wr_q;
  logic [PW:0]      rd_q;
  logic             push;
  logic             pop;

  assign out_valid = (wr_q != rd_q);
  assign in_ready  = (wr_q[PW-1:0] != rd_q[PW-1:0]) || (wr_q[PW] == rd_q[PW]);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[PW-1:0]];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// ### hdl/eee_gate_pkg.sv
// Constants, register map and state encoding for the EEE transmit gating block.
// Assumes a 40 MHz pclk; cycle counts below derive from that period.
package eee_gate_pkg;
  localparam int DATA_W       = 32;
  localparam int APB_AW       = 8;
  localparam int CLK_NS       = 25;
  localparam int WAKE_GIG_NS  = 17000;
  localparam int WAKE_OTH_NS  = 30000;
  localparam int DEFER_MAX_NS = 48000;
  localparam int BYTE_THRESH  = 3000;
  // Least times round up, longest times round down
  localparam int WAKE_GIG_CYC = (WAKE_GIG_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_OTH_CYC = (WAKE_OTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEFER_CYC    = DEFER_MAX_NS / CLK_NS;
  localparam int CNT_W        = 12;
  localparam int ADD_W        = 12;
  localparam int ACC_W        = 13;
  localparam int FIFO_DEPTH   = 8;
  // Register byte offsets
  localparam logic [APB_AW-1:0] REG_ENABLE   = 8'h00;
  localparam logic [APB_AW-1:0] REG_WAKE_GIG = 8'h04;
  localparam logic [APB_AW-1:0] REG_WAKE_OTH = 8'h08;
  localparam logic [APB_AW-1:0] REG_STATUS   = 8'h0C;
  localparam logic [2:0]        URG_REGION   = 3'h1;
  localparam int                URG_IDX_LSB  = 2;
  localparam int                URG_REG_LSB  = 5;
  localparam int                STAT_ACT_LSB = 8;
  localparam int                MAX_PORTS    = 8;
  localparam int                MAX_QUEUES   = 8;
  localparam logic [CNT_W-1:0]  WAKE_GIG_RST = CNT_W'(WAKE_GIG_CYC);
  localparam logic [CNT_W-1:0]  WAKE_OTH_RST = CNT_W'(WAKE_OTH_CYC);
  typedef enum logic [1:0] {
    PW_SLEEP  = 2'b00,
    PW_DEFER  = 2'b01,
    PW_WAKE   = 2'b10,
    PW_ACTIVE = 2'b11
  } pw_state_t;
endpackage

// ### hdl/gate_fifo.sv
// No logic here: the word FIFO module sits in eee_tx_gate.sv beside its only user.
// Assumes that file is part of every build that needs the FIFO.

// ### bench/eee_tx_gate_checker.sv
// Port-level checker for the EEE transmit gating block.
// Assumes the wake registers are never set below MIN_WAKE cycles.
`timescale 1ns/1ps
module eee_tx_gate_checker
  import eee_gate_pkg::*;
#(
  parameter int NUM_PORTS = 8,
  parameter int MIN_WAKE  = 680
) (
  input wire logic                                 pclk,
  input wire logic                                 presetn,
  input wire logic                                 psel,
  input wire logic                                 penable,
  input wire logic                                 pwrite,
  input wire logic [DATA_W-1:0]                    prdata,
  input wire logic                                 pready,
  input wire logic                                 pslverr,
  input wire logic [NUM_PORTS-1:0]                 q_add_valid,
  input wire logic [NUM_PORTS-1:0]                 q_empty,
  input wire logic                                 tx_valid,
  input wire logic                                 tx_ready,
  input wire logic [$clog2(NUM_PORTS)-1:0]         tx_port,
  input wire logic [DATA_W-1:0]                    tx_data,
  input wire logic [NUM_PORTS-1:0]                 tx_power_up
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [11:0] up_q [NUM_PORTS];
  logic [11:0] wait_q;
  // Saturates so a long-powered port never wraps back under the wake time
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (!presetn) up_q[i] <= '0;
      else if (!tx_power_up[i]) up_q[i] <= '0;
      else if (up_q[i] != 12'hFFF) up_q[i] <= up_q[i] + 12'h001;
    end
  end
  // Deferral age of port 1, from its first enqueue while asleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_q <= '0;
    else if (tx_power_up[1]) wait_q <= '0;
    else if (wait_q != '0 || q_add_valid[1]) wait_q <= wait_q + 12'h001;
  end
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  property p_tx_hold; s_stall |=> tx_valid && $stable(tx_data) && $stable(tx_port); endproperty
  property p_tx_powered; tx_valid |-> tx_power_up[tx_port]; endproperty
  property p_wake_len; tx_valid |-> up_q[tx_port] >= 12'(MIN_WAKE); endproperty
  property p_sleep_empty; $fell(tx_power_up[0]) |-> $past(q_empty[0]) && !$past(q_add_valid[0]); endproperty
  property p_defer_bound; wait_q <= 12'(DEFER_CYC + 1); endproperty
  property p_err_access; pslverr |-> psel && penable; endproperty
  property p_rdata_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
  property p_ready; pready; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word changed while stalled");
  a_tx_powered: assert property (p_tx_powered) else $error("word sent on unpowered port");
  a_wake_len: assert property (p_wake_len) else $error("word sent before wake time");
  a_sleep_empty: assert property (p_sleep_empty) else $error("power dropped with data");
  a_defer_bound: assert property (p_defer_bound) else $error("deferral too long");
  a_err_access: assert property (p_err_access) else $error("error outside access phase");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule
bind eee_tx_gate eee_tx_gate_checker #(.NUM_PORTS(NUM_PORTS)) i_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .q_add_valid(q_add_valid), .q_empty(q_empty), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_port(tx_port), .tx_data(tx_data), .tx_power_up(tx_power_up));

// ### bench/mac_partner.sv
// Link partner stand-in at the MAC side: takes words and logs them.
// Assumes one clock; stall is driven by the bench.
`timescale 1ns/1ps
module mac_partner (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [2:0]  tx_port,
  input  wire logic [31:0] tx_data,
  output logic             tx_ready
);
  logic [31:0] got [0:15];
  logic [2:0]  got_port [0:15];
  int          got_n;
  // Wake time agreed with the device is the value the bench writes, 800 cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      got_n <= 0;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready && got_n < 16) begin
        got[got_n] <= tx_data;
        got_port[got_n] <= tx_port;
        got_n <= got_n + 1;
      end
    end
  end
endmodule

// ### bench/eee_tx_gate_tb.sv
// Self-checking bench for the EEE transmit gating block.
// Assumes a 40 MHz pclk and the MAC stand-in on the transmit side.
`timescale 1ns/1ps
module eee_tx_gate_tb;
  import eee_gate_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [7:0] paddr = '0, q_add_valid = '0, q_empty = 8'hFF, link_gig = 8'hFD, tx_power_up;
  logic [31:0] pwdata = '0, prdata, rd, in_data = '0, tx_data;
  logic [3:0] pstrb = 4'hF;
  logic [95:0] q_add_bytes = '0;
  logic [23:0] q_add_queue = '0;
  logic in_valid = 0, in_ready, tx_valid, tx_ready, stall = 0;
  logic [2:0] in_port = '0, tx_port;
  int err_total = 0, checks = 0, cyc = 0, n;
  always #12.5 pclk = ~pclk;
  eee_tx_gate i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .q_add_valid, .q_add_bytes, .q_add_queue, .q_empty, .link_gig, .in_valid,
    .in_ready, .in_port, .in_data, .tx_valid, .tx_ready, .tx_port, .tx_data, .tx_power_up);
  mac_partner i_mac (.pclk, .presetn, .stall, .tx_valid, .tx_port, .tx_data, .tx_ready);
  task end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task add(input int p, input logic [11:0] b, input logic [2:0] q);
    q_add_valid[p] <= 1; q_add_bytes[p*12+:12] <= b; q_add_queue[p*3+:3] <= q;
    @(posedge pclk); q_add_valid <= '0;
    @(posedge pclk);
  endtask
  task push(input logic [2:0] p, input logic [31:0] d);
    in_valid <= 1; in_port <= p; in_data <= d;
    // Held until taken; in_ready is read mid-cycle, where it has settled
    @(negedge pclk);
    while (in_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk); in_valid <= 0;
    @(posedge pclk);
  endtask
  task wait_power(input int p);
    n = 0;
    while (tx_power_up[p] !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
  endtask
  task wait_tx;
    n = 0;
    while (tx_valid !== 1'b1 && n < 3000) begin @(posedge pclk); n++; end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 12000) begin err_total++; end_of_test; end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, REG_ENABLE, 0); check(rd, 0);
    apb(0, REG_WAKE_GIG, 0); check(rd, 32'h2A8);
    apb(0, REG_WAKE_OTH, 0); check(rd, 32'h4B0);
    apb(0, 8'h24, 0); check(rd, 0);
    apb(0, 8'h40, 0); check({er, rd[30:0]}, 32'h8000_0000);
    apb(1, REG_STATUS, 32'hFFFF_FFFF); check(er, 0);
    apb(1, REG_ENABLE, 32'h3);
    pstrb <= 4'h1;
    apb(1, REG_WAKE_OTH, 32'hFFFF_FF20);
    pstrb <= 4'hF;
    apb(0, REG_WAKE_OTH, 0); check(rd, 32'h420);
    apb(1, REG_WAKE_OTH, 32'h320); apb(0, REG_WAKE_OTH, 0); check(rd, 32'h320);
    repeat (1300) @(posedge pclk);
    apb(0, REG_STATUS, 0); check(rd, 32'hFCFC);
    // One byte short of the threshold must not wake the port
    q_empty[0] <= 0;
    add(0, 1500, 0); add(0, 1499, 5); check(tx_power_up[0], 0);
    add(0, 1, 0); check(tx_power_up[0], 1);
    push(0, 32'h77);
    wait_tx; check(n inside {[675:685]}, 1);
    repeat (1300) @(posedge pclk); check(tx_power_up[0], 1);
    q_empty[0] <= 1;
    repeat (3) @(posedge pclk); check(tx_power_up[0], 0);
    add(0, 3000, 0); check(tx_power_up[0], 1);
    add(1, 100, 0); wait_power(1); check(n inside {[DEFER_CYC-4:DEFER_CYC]}, 1);
    push(1, 32'h55); wait_tx; check(n inside {[795:805]}, 1);
    apb(1, 8'h24, 32'h4); check(tx_power_up[1], 0);
    add(1, 64, 2); check(tx_power_up[1], 1);
    // Far side stalls: output register plus 8 queued words, then refusal
    stall <= 1;
    for (int k = 0; k < 9; k++) push(3, 32'hA0 + k);
    @(negedge pclk);
    check(in_ready, 0);
    @(posedge pclk);
    stall <= 0;
    repeat (30) @(posedge pclk);
    check(i_mac.got_n, 11);
    check({i_mac.got_port[0], i_mac.got[0][28:0]}, 32'h0000_0077);
    check({i_mac.got_port[1], i_mac.got[1][28:0]}, 32'h2000_0055);
    for (int k = 0; k < 9; k++) check(i_mac.got[k+2], 32'hA0 + k);
    end_of_test;
  end
endmodule
